// ===== src/evrt_pkg.sv
// constants and carrier types for the four-channel event routing fabric
// assumes one peripheral clock and a byte-wide register port
package evrt_pkg;

  localparam int NCH = 4;
  localparam int NPORT = 6;
  localparam int NTMR = 5;
  localparam int PRESC_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [4:0] OFS_SEL0 = 5'h00;
  localparam logic [4:0] OFS_SEL3 = 5'h03;
  localparam logic [4:0] OFS_CTRL0 = 5'h08;
  localparam logic [4:0] OFS_CTRL3 = 5'h0b;
  localparam logic [4:0] OFS_TRIG = 5'h10;
  localparam logic [4:0] OFS_VALUE = 5'h11;
  localparam logic [7:0] RST_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // channel control fields
  localparam int CTRL_RSV_BIT = 7;
  localparam int IRM_HI = 6;
  localparam int IRM_LO = 5;
  localparam int IDXEN_BIT = 4;
  localparam int QUAD_DECODE_ENABLE_BIT = 3;
  localparam int FLT_HI = 2;
  localparam logic [7:0] CTRL_WMASK_QUAD = 8'h7f;
  localparam logic [7:0] CTRL_WMASK_PLAIN = 8'h07;
  localparam logic [3:0] QUAD_CH_MASK = 4'h5;

  ////////////////////////////////////////////////////////////////////////////
  // selector encoding
  localparam logic [7:0] SEL_NONE = 8'h00;
  localparam logic [7:0] SEL_USB = 8'h0a;
  localparam logic [3:0] HI_NONE = 4'h0;
  localparam logic [3:0] HI_PORT_FIRST = 4'h5;
  localparam logic [3:0] HI_PORT_MID = 4'h6;
  localparam logic [3:0] HI_PORT_LAST = 4'h7;
  localparam logic [3:0] HI_PRESC = 4'h8;
  localparam logic [3:0] HI_TMR_C = 4'hc;
  localparam logic [3:0] HI_TMR_D = 4'hd;
  localparam logic [3:0] HI_TMR_E = 4'he;
  localparam logic [3:0] HI_TMR_F = 4'hf;
  localparam logic [3:0] HI_TMR_BASE = 4'hb;
  localparam logic [2:0] TMR_SECOND = 3'h1;
  localparam logic [2:0] TT_WRAP = 3'h0;
  localparam logic [2:0] TT_FAULT = 3'h1;
  localparam logic [2:0] TT_A = 3'h4;
  localparam logic [2:0] TT_B = 3'h5;
  localparam logic [2:0] TT_C = 3'h6;
  localparam logic [2:0] TT_D = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // carriers and state
  typedef struct packed {
    logic timer_wrap_event;
    logic timer_fault_event;
    logic timer_match_a_event;
    logic timer_match_b_event;
    logic timer_match_c_event;
    logic timer_match_d_event;
  } evrt_tmr_t;

  typedef struct packed {
    logic ev;
    logic dat;
  } evrt_chan_t;

  typedef struct packed {
    logic [1:0] smp;
    logic [2:0] cnt;
    logic [1:0] lvl;
  } evrt_flt_state_t;

  typedef struct packed {
    logic [NCH-1:0][7:0] sel;
    logic [NCH-1:0][7:0] ctrl;
    logic [7:0] trig;
    logic [7:0] value;
    logic [PRESC_W-1:0] presc;
    logic [7:0] rdata;
    evrt_chan_t [NCH-1:0] out;
    logic [NCH-1:0][1:0] qprev;
    logic [1:0] idx_prev;
    logic [1:0] idx_out;
  } evrt_state_t;

endpackage

// ===== src/evrt_filter.sv
// per-channel sample filter over a two-bit source (event / adjacent phase)
// assumes the source is synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module evrt_filter (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // source and filter length
  input wire logic [1:0] raw,
  input wire logic [2:0] len,
  // filtered level
  output logic [1:0] lvl
);

  evrt_pkg::evrt_flt_state_t q_r;
  evrt_pkg::evrt_flt_state_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.smp = raw;
    if (raw == q_r.smp) begin
      if (q_r.cnt != 3'h7) begin
        q_nxt.cnt = q_r.cnt + 3'h1;
      end
    end else begin
      q_nxt.cnt = 3'h0;
    end
    if (q_nxt.cnt >= len) begin
      q_nxt.lvl = raw;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign lvl = q_r.lvl;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_filter_settle_len: assert property (
    $changed(q_r.lvl) |-> (q_r.cnt >= $past(len)))
    else $error("filtered level changed before enough samples");

endmodule
`default_nettype wire

// ===== src/evrt_top.sv
// event routing fabric: four channels, source selectors, filters,
// quadrature decode on channels 0 and 2, manual events
// assumes sources synchronous to mclk, byte register port with
// read data returned one cycle after the read strobe
//
// Operation
// - codes 0101-0111 route port pin n
// - code 1000 routes clock divided by 2^M
// - nibbles 1100-1111 select timer group
// - timer type field selects wrap/fault/match
// - usb selection differs per channel 0-3
// - control bit 7 reads zero
// - index mode selects qualifying phase state
// - quadrature fields only on channels 0,2
// - index enable generates index data event
// - decode enable switches channel to quadrature
// - event passes after filter+1 equal samples
// - strobe write sets channels from strobe/data
// - manual event lasts one clock
// - zero selector routes no peripheral event
// - absent peripheral behaves as zero selector
// - phase90 leading phase0 means forward
`timescale 1ns/1ns
`default_nettype none
module evrt_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // event sources
  input wire logic [evrt_pkg::NPORT-1:0][7:0] port_pin_source,
  input wire evrt_pkg::evrt_tmr_t [evrt_pkg::NTMR-1:0] timer_events,
  input wire logic [evrt_pkg::NCH-1:0] usb_evt,
  input wire logic [1:0] index_input,
  // channel outputs
  output evrt_pkg::evrt_chan_t [evrt_pkg::NCH-1:0] chan_evt,
  output logic [1:0] index_evt
);

  evrt_pkg::evrt_state_t q_r;
  evrt_pkg::evrt_state_t q_nxt;

  logic [evrt_pkg::NCH-1:0][1:0] src;
  logic [evrt_pkg::NCH-1:0][1:0] flt;
  logic [evrt_pkg::NCH-1:0][1:0] phase;
  logic [evrt_pkg::NCH-1:0] man;
  logic [evrt_pkg::NCH-1:0] fwd;
  logic [evrt_pkg::NCH-1:0] rev;
  logic [evrt_pkg::NCH-1:0] quad_on;
  logic [1:0] idx_match;
  logic trig_wr;

  assign trig_wr = wr && (addr == evrt_pkg::OFS_TRIG);

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  function automatic logic [1:0] route_fn(
    input logic [7:0] s,
    input logic usb,
    input logic [evrt_pkg::NPORT-1:0][7:0] pins,
    input evrt_pkg::evrt_tmr_t [evrt_pkg::NTMR-1:0] tmr,
    input logic [evrt_pkg::PRESC_W-1:0] pc
  );
    logic [3:0] hi;
    logic [2:0] lo;
    logic [2:0] port;
    logic [2:0] tix;
    logic [evrt_pkg::PRESC_W-1:0] mask;
    evrt_pkg::evrt_tmr_t t;
    hi = s[7:4];
    lo = s[2:0];
    port = 3'h0;
    tix = 3'h0;
    mask = '0;
    t = '0;
    route_fn = 2'b00;
    case (hi)
      // usb event private to each channel
      evrt_pkg::HI_NONE: begin
        route_fn = {1'b0, (s == evrt_pkg::SEL_USB) & usb};
      end
      // port pin, plus the next pin as phase90
      evrt_pkg::HI_PORT_FIRST, evrt_pkg::HI_PORT_MID, evrt_pkg::HI_PORT_LAST: begin
        port = {hi[1:0] - 2'h1, s[3]};
        route_fn = {pins[port][lo + 3'h1], pins[port][lo]};
      end
      evrt_pkg::HI_PRESC: begin
        mask = evrt_pkg::PRESC_W'((17'h1 << s[3:0]) - 17'h1);
        route_fn = {1'b0, &(pc | ~mask)};
      end
      evrt_pkg::HI_TMR_C, evrt_pkg::HI_TMR_D, evrt_pkg::HI_TMR_E, evrt_pkg::HI_TMR_F: begin
        if (hi == evrt_pkg::HI_TMR_C) begin
          tix = {2'b00, s[3]};
        end else begin
          tix = 3'(hi - evrt_pkg::HI_TMR_BASE);
        end
        t = tmr[tix];
        if (!s[3] || hi == evrt_pkg::HI_TMR_C) begin
          case (lo)
            evrt_pkg::TT_WRAP: route_fn = {1'b0, t.timer_wrap_event};
            evrt_pkg::TT_FAULT: route_fn = {1'b0, t.timer_fault_event};
            evrt_pkg::TT_A: route_fn = {1'b0, t.timer_match_a_event};
            evrt_pkg::TT_B: route_fn = {1'b0, t.timer_match_b_event};
            evrt_pkg::TT_C: route_fn = {1'b0, t.timer_match_c_event & (tix != evrt_pkg::TMR_SECOND)};
            evrt_pkg::TT_D: route_fn = {1'b0, t.timer_match_d_event & (tix != evrt_pkg::TMR_SECOND)};
            default: route_fn = 2'b00;
          endcase
        end
      end
      // reserved codes act as a zero selector
      default: route_fn = 2'b00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-channel routing, filtering and quadrature step
  for (genvar g = 0; g < evrt_pkg::NCH; g++) begin : g_ch
    // zero selector yields a quiet source
    // absent peripherals read as quiet inputs
    assign src[g] = route_fn(q_r.sel[g], usb_evt[g], port_pin_source, timer_events, q_r.presc);

    evrt_filter u_flt (
      .mclk(mclk),
      .rst(rst),
      .raw(src[g]),
      .len(q_r.ctrl[g][evrt_pkg::FLT_HI:0]),
      .lvl(flt[g])
    );

    // channel set when its strobe or data bit is set
    assign man[g] = trig_wr && (wdata[g] || q_r.value[g]);
    // decode only where the fields exist
    assign quad_on[g] = evrt_pkg::QUAD_CH_MASK[g] && q_r.ctrl[g][evrt_pkg::QUAD_DECODE_ENABLE_BIT];
    assign phase[g] = {flt[g][0], flt[g][1]};
    assign fwd[g] = (q_r.qprev[g] == 2'b00 && phase[g] == 2'b01) ||
                    (q_r.qprev[g] == 2'b01 && phase[g] == 2'b11) ||
                    (q_r.qprev[g] == 2'b11 && phase[g] == 2'b10) ||
                    (q_r.qprev[g] == 2'b10 && phase[g] == 2'b00);
    assign rev[g] = (q_r.qprev[g] == 2'b00 && phase[g] == 2'b10) ||
                    (q_r.qprev[g] == 2'b10 && phase[g] == 2'b11) ||
                    (q_r.qprev[g] == 2'b11 && phase[g] == 2'b01) ||
                    (q_r.qprev[g] == 2'b01 && phase[g] == 2'b00);
  end

  for (genvar k = 0; k < 2; k++) begin : g_idx
    assign idx_match[k] = q_r.ctrl[2*k][evrt_pkg::IDXEN_BIT] && index_input[k] &&
                          (phase[2*k] == q_r.ctrl[2*k][evrt_pkg::IRM_HI:evrt_pkg::IRM_LO]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux
  function automatic logic [7:0] read_fn(input logic [4:0] a, input evrt_pkg::evrt_state_t s);
    read_fn = 8'h00;
    if (a <= evrt_pkg::OFS_SEL3) begin
      read_fn = s.sel[a[1:0]];
    end else if (a >= evrt_pkg::OFS_CTRL0 && a <= evrt_pkg::OFS_CTRL3) begin
      read_fn = s.ctrl[a[1:0]];
    end else if (a == evrt_pkg::OFS_TRIG) begin
      read_fn = s.trig;
    end else if (a == evrt_pkg::OFS_VALUE) begin
      read_fn = s.value;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    q_nxt = q_r;
    q_nxt.presc = q_r.presc + 16'h1;
    q_nxt.rdata = rd ? read_fn(addr, q_r) : 8'h00;
    if (wr) begin
      if (addr <= evrt_pkg::OFS_SEL3) begin
        q_nxt.sel[addr[1:0]] = wdata;
      end else if (addr >= evrt_pkg::OFS_CTRL0 && addr <= evrt_pkg::OFS_CTRL3) begin
        // quadrature bits held zero on channels 1,3
        if (evrt_pkg::QUAD_CH_MASK[addr[1:0]]) begin
          q_nxt.ctrl[addr[1:0]] = wdata & evrt_pkg::CTRL_WMASK_QUAD;
        end else begin
          q_nxt.ctrl[addr[1:0]] = wdata & evrt_pkg::CTRL_WMASK_PLAIN;
        end
      end else if (addr == evrt_pkg::OFS_TRIG) begin
        q_nxt.trig = wdata;
      end else if (addr == evrt_pkg::OFS_VALUE) begin
        q_nxt.value = wdata;
      end
    end
    for (int i = 0; i < evrt_pkg::NCH; i++) begin
      q_nxt.qprev[i] = phase[i];
      if (man[i]) begin
        // one-cycle manual event overrides the source
        // data value taken from the earlier data write
        q_nxt.out[i].ev = wdata[i];
        q_nxt.out[i].dat = q_r.value[i];
      end else if (quad_on[i]) begin
        q_nxt.out[i].ev = fwd[i] || rev[i];
        q_nxt.out[i].dat = fwd[i];
      end else begin
        q_nxt.out[i].ev = flt[i][0];
        q_nxt.out[i].dat = 1'b0;
      end
    end
    q_nxt.idx_prev = idx_match;
    q_nxt.idx_out = idx_match & ~q_r.idx_prev;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rdata = q_r.rdata;
  assign chan_evt = q_r.out;
  assign index_evt = q_r.idx_out;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_ctrl_bit7_zero: assert property (
    (rd && addr >= evrt_pkg::OFS_CTRL0 && addr <= evrt_pkg::OFS_CTRL3)
    |=> (rdata[evrt_pkg::CTRL_RSV_BIT] == 1'b0))
    else $error("control bit 7 read nonzero");

  a_odd_ctrl_reserved: assert property (
    (rd && addr == evrt_pkg::OFS_CTRL0 + 5'h1) |=> (rdata[evrt_pkg::IRM_HI:evrt_pkg::QUAD_DECODE_ENABLE_BIT] == 4'h0))
    else $error("channel 1 quadrature bits read nonzero");

  a_manual_event_value: assert property (
    (trig_wr && (wdata[0] || q_r.value[0]))
    |=> (chan_evt[0].ev == $past(wdata[0]) && chan_evt[0].dat == $past(q_r.value[0])))
    else $error("manual event on channel 0 wrong");

  a_manual_one_cycle: assert property (
    (trig_wr && wdata[1] && q_r.sel[1] == evrt_pkg::SEL_NONE && flt[1][0] == 1'b0)
    ##1 (!trig_wr && q_r.sel[1] == evrt_pkg::SEL_NONE)
    |=> !chan_evt[1].ev)
    else $error("manual event lasted more than one cycle");

  a_zero_sel_quiet: assert property (
    (q_r.sel[0] == evrt_pkg::SEL_NONE && q_r.ctrl[0] == evrt_pkg::RST_BYTE && !man[0])[*3]
    |=> !chan_evt[0].ev)
    else $error("zero selector passed an event");

  a_timer_wrap_route: assert property (
    (q_r.sel[1] == {evrt_pkg::HI_TMR_C, 1'b0, evrt_pkg::TT_WRAP} &&
     q_r.ctrl[1] == evrt_pkg::RST_BYTE && timer_events[0].timer_wrap_event && !man[1])[*3]
    |=> chan_evt[1].ev)
    else $error("timer wrap event not routed");

  a_port_pin_route: assert property (
    (q_r.sel[1] == {evrt_pkg::HI_PORT_FIRST, 1'b1, 3'h3} &&
     q_r.ctrl[1] == evrt_pkg::RST_BYTE && port_pin_source[1][3] && !man[1])[*3]
    |=> chan_evt[1].ev)
    else $error("port pin event not routed");

  a_reserved_quiet: assert property (
    (q_r.sel[1][7:4] == evrt_pkg::HI_PRESC + 4'h1 && q_r.ctrl[1] == evrt_pkg::RST_BYTE &&
     !man[1])[*3]
    |=> !chan_evt[1].ev)
    else $error("reserved selector passed an event");

  a_index_mode_match: assert property (
    index_evt[0] |-> ($past(q_r.ctrl[0][evrt_pkg::IDXEN_BIT]) &&
                      $past(phase[0]) == $past(q_r.ctrl[0][evrt_pkg::IRM_HI:evrt_pkg::IRM_LO])))
    else $error("index event outside qualifying state");

  a_ch3_quad_reserved: assert property (
    (rd && addr == evrt_pkg::OFS_CTRL3) |=> (rdata[evrt_pkg::IRM_HI:evrt_pkg::QUAD_DECODE_ENABLE_BIT] == 4'h0))
    else $error("channel 3 quadrature bits read nonzero");

  a_presc_tap_high: assert property (
    (q_r.sel[2] == {evrt_pkg::HI_PRESC, 4'h0} && q_r.ctrl[2] == evrt_pkg::RST_BYTE &&
     !man[2])[*3]
    |=> chan_evt[2].ev)
    else $error("undivided prescaler tap not high");

  a_group_f_wrap: assert property (
    (q_r.sel[1] == {evrt_pkg::HI_TMR_F, 1'b0, evrt_pkg::TT_WRAP} &&
     q_r.ctrl[1] == evrt_pkg::RST_BYTE && timer_events[4].timer_wrap_event &&
     !man[1])[*3]
    |=> chan_evt[1].ev)
    else $error("last timer group wrap not routed");

  a_second_timer_cd: assert property (
    (q_r.sel[1] == {evrt_pkg::HI_TMR_C, 1'b1, evrt_pkg::TT_C} &&
     q_r.ctrl[1] == evrt_pkg::RST_BYTE && !man[1])[*3]
    |=> !chan_evt[1].ev)
    else $error("second timer match c routed");

  a_usb_private: assert property (
    (q_r.sel[3] == evrt_pkg::SEL_USB && q_r.ctrl[3] == evrt_pkg::RST_BYTE &&
     !usb_evt[3] && !man[3])[*3]
    |=> !chan_evt[3].ev)
    else $error("foreign usb event reached channel 3");

  a_index_needs_enable: assert property (
    !q_r.ctrl[0][evrt_pkg::IDXEN_BIT] |=> !index_evt[0])
    else $error("index event without index enable");

  a_quad_jump_quiet: assert property (
    (quad_on[0] && !man[0] && q_r.qprev[0] == 2'b00 && phase[0] == 2'b11)
    |=> !chan_evt[0].ev)
    else $error("quadrature double jump produced a step");

  a_quad_forward: assert property (
    (quad_on[0] && !man[0] && q_r.qprev[0] == 2'b00 && phase[0] == 2'b01)
    |=> (chan_evt[0].ev && chan_evt[0].dat))
    else $error("phase90 lead not a forward step");

  a_quad_reverse: assert property (
    (quad_on[0] && !man[0] && q_r.qprev[0] == 2'b01 && phase[0] == 2'b00)
    |=> (chan_evt[0].ev && !chan_evt[0].dat))
    else $error("phase0 lead not a reverse step");

  a_manual_any_sel: assert property (
    (trig_wr && wdata[1]) |=> chan_evt[1].ev)
    else $error("manual event did not reach channel 1");

  c_manual_event: cover property (trig_wr && wdata[0] ##1 chan_evt[0].ev);
  c_quad_step: cover property (quad_on[0] ##1 chan_evt[0].ev && chan_evt[0].dat);
  c_index_event: cover property (index_evt[0]);
  c_presc_route: cover property (q_r.sel[2][7:4] == evrt_pkg::HI_PRESC ##3 chan_evt[2].ev);

endmodule
`default_nettype wire

// ===== tb/evrt_src_model.sv
// far-side event sources: port pins, timer events, usb events, index lines
// assumes the bench calls the setters between clock edges
`timescale 1ns/1ns
`default_nettype none
module evrt_src_model (
  // sources toward the fabric
  output logic [evrt_pkg::NPORT-1:0][7:0] port_pin_source,
  output evrt_pkg::evrt_tmr_t [evrt_pkg::NTMR-1:0] timer_events,
  output logic [evrt_pkg::NCH-1:0] usb_evt,
  output logic [1:0] index_input
);
  initial begin
    port_pin_source = '0;
    timer_events = '0;
    usb_evt = '0;
    index_input = '0;
  end
  // phase0 on pin n, phase90 on pin n+1
  task automatic set_pin(input int p, input int n, input logic v);
    port_pin_source[p][n] <= v;
  endtask
  task automatic set_tmr(input int i, input logic [5:0] v);
    timer_events[i] <= v;
  endtask
  task automatic set_usb(input logic [3:0] v);
    usb_evt <= v;
  endtask
  // index only where an encoder index exists
  task automatic set_idx(input logic [1:0] v);
    index_input <= v;
  endtask
endmodule
`default_nettype wire

// ===== tb/evrt_top_tb.sv
// self-checking bench for the event routing fabric
// assumes evrt_top and the source model; one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module evrt_top_tb;
  logic mclk, rst, wr, rd;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [evrt_pkg::NPORT-1:0][7:0] pins;
  evrt_pkg::evrt_tmr_t [evrt_pkg::NTMR-1:0] tmr;
  logic [3:0] usb;
  logic [1:0] idx, index_evt;
  evrt_pkg::evrt_chan_t [evrt_pkg::NCH-1:0] chan_evt;
  logic dv;
  int err_count, num_checks, cnt;
  logic [7:0] resv [6] = '{8'h08, 8'h40, 8'h90, 8'ha5, 8'hb0, 8'hd8};
  logic [2:0] tt [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};

  evrt_top u_evrt_top (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .port_pin_source(pins), .timer_events(tmr), .usb_evt(usb),
    .index_input(idx), .chan_evt(chan_evt), .index_evt(index_evt));
  evrt_src_model u_evrt_src_model (.port_pin_source(pins), .timer_events(tmr),
    .usb_evt(usb), .index_input(idx));

  ////////////////////////////////////////////////////////////////////////////
  // bus and check tasks
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic evc(input int ch, input logic e);
    chk("channel event", {7'h00, chan_evt[ch].ev}, {7'h00, e});
  endtask
  task automatic cnt_ev(input int ch, input int n);
    cnt = 0;
    repeat (n) begin
      tick(1);
      if (chan_evt[ch].ev === 1'b1) begin
        cnt++;
        dv = chan_evt[ch].dat;
      end
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #500000;
    err_count++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 5'h00; wdata = 8'h00;
    err_count = 0; num_checks = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // reset values and register access
    for (int a = 0; a < 18; a++) begin
      rd_reg(5'(a));
      chk("reset value", rv, 8'h00);
    end
    for (int c = 0; c < 4; c++) wr_reg(5'h08 + 5'(c), 8'hff);
    for (int c = 0; c < 4; c++) begin
      rd_reg(5'h08 + 5'(c));
      chk("control readback", rv, (c % 2 == 0) ? 8'h7f : 8'h07);
    end
    for (int c = 0; c < 4; c++) wr_reg(5'h08 + 5'(c), 8'h00);
    wr_reg(5'h02, 8'h5b);
    rd_reg(5'h02);
    chk("selector readback", rv, 8'h5b);
    wr_reg(5'h04, 8'hff);
    rd_reg(5'h04);
    chk("unmapped read", rv, 8'h00);
    // filter length boundary on channel 3
    wr_reg(5'h03, 8'h67);
    wr_reg(5'h0b, 8'h07);
    tick(4);
    u_evrt_src_model.set_pin(2, 7, 1'b1);
    tick(8);
    evc(3, 1'b0);
    tick(1);
    evc(3, 1'b1);
    wr_reg(5'h0b, 8'h00);
    // each port code and bank bit
    for (int p = 0; p < 6; p++) begin
      wr_reg(5'h01, {4'h5 + 4'(p / 2), 1'(p % 2), 3'h3});
      u_evrt_src_model.set_pin(p, 3, 1'b1);
      tick(4);
      evc(1, 1'b1);
      u_evrt_src_model.set_pin(p, 3, 1'b0);
      tick(4);
      evc(1, 1'b0);
    end
    // timer event types
    for (int k = 0; k < 6; k++) begin
      wr_reg(5'h01, {5'h18, tt[k]});
      u_evrt_src_model.set_tmr(0, 6'h20 >> k);
      tick(4);
      evc(1, 1'b1);
    end
    u_evrt_src_model.set_tmr(1, 6'h03);
    wr_reg(5'h01, 8'hce);
    tick(4);
    evc(1, 1'b0);
    u_evrt_src_model.set_tmr(4, 6'h20);
    wr_reg(5'h01, 8'hf0);
    tick(4);
    evc(1, 1'b1);
    // all pins and timers active, reserved and zero selectors stay quiet
    for (int p = 0; p < 6; p++)
      for (int n = 0; n < 8; n++) u_evrt_src_model.set_pin(p, n, 1'b1);
    for (int i = 0; i < 5; i++) u_evrt_src_model.set_tmr(i, 6'h3f);
    for (int r = 0; r < 6; r++) begin
      wr_reg(5'h01, resv[r]);
      tick(4);
      evc(1, 1'b0);
    end
    wr_reg(5'h01, 8'hc2);
    tick(4);
    evc(1, 1'b0);
    wr_reg(5'h01, 8'h00);
    tick(4);
    evc(1, 1'b0);
    for (int p = 0; p < 6; p++)
      for (int n = 0; n < 8; n++) u_evrt_src_model.set_pin(p, n, 1'b0);
    // usb events per channel
    for (int c = 0; c < 4; c++) wr_reg(5'(c), 8'h0a);
    for (int k = 0; k < 4; k++) begin
      u_evrt_src_model.set_usb(4'h1 << k);
      tick(4);
      for (int c = 0; c < 4; c++) evc(c, 1'(c == k));
    end
    u_evrt_src_model.set_usb(4'h0);
    // manual events with zero selectors
    for (int c = 0; c < 4; c++) wr_reg(5'(c), 8'h00);
    wr_reg(5'h11, 8'h02);
    wr_reg(5'h10, 8'h03);
    #1;
    chk("manual ch0", {6'h00, chan_evt[0]}, 8'h02);
    chk("manual ch1", {6'h00, chan_evt[1]}, 8'h03);
    evc(2, 1'b0);
    tick(1);
    evc(0, 1'b0);
    evc(1, 1'b0);
    rd_reg(5'h10);
    chk("strobe readback", rv, 8'h03);
    // prescaler taps
    wr_reg(5'h02, 8'h80);
    tick(4);
    cnt_ev(2, 4);
    chk("prescaler m0", 8'(cnt), 8'h04);
    wr_reg(5'h02, 8'h82);
    tick(4);
    cnt_ev(2, 16);
    chk("prescaler m2", 8'(cnt), 8'h04);
    // quadrature on channel 0, pins 0 and 1 of the first port
    wr_reg(5'h00, 8'h50);
    wr_reg(5'h08, 8'h08);
    tick(4);
    u_evrt_src_model.set_pin(0, 1, 1'b1);
    cnt_ev(0, 6);
    chk("forward steps", 8'(cnt), 8'h01);
    chk("forward dir", {7'h00, dv}, 8'h01);
    u_evrt_src_model.set_pin(0, 1, 1'b0);
    cnt_ev(0, 6);
    chk("reverse steps", 8'(cnt), 8'h01);
    chk("reverse dir", {7'h00, dv}, 8'h00);
    u_evrt_src_model.set_pin(0, 0, 1'b1);
    u_evrt_src_model.set_pin(0, 1, 1'b1);
    cnt_ev(0, 6);
    chk("double jump", 8'(cnt), 8'h00);
    // index recognition modes
    for (int m = 0; m < 4; m++) begin
      wr_reg(5'h08, {1'b0, 2'(m), 5'h18});
      u_evrt_src_model.set_pin(0, 0, 1'(m >> 1));
      u_evrt_src_model.set_pin(0, 1, 1'(m & 1));
      tick(4);
      u_evrt_src_model.set_idx(2'h1);
      cnt = 0;
      repeat (6) begin
        tick(1);
        if (index_evt[0] === 1'b1) cnt++;
      end
      chk("index pulses", 8'(cnt), 8'h01);
      u_evrt_src_model.set_idx(2'h0);
      tick(2);
    end
    wr_reg(5'h08, 8'h18);
    u_evrt_src_model.set_idx(2'h1);
    cnt = 0;
    repeat (6) begin
      tick(1);
      if (index_evt[0] === 1'b1) cnt++;
    end
    chk("index mismatch", 8'(cnt), 8'h00);
    // index on channel 2, phase pins 2 and 3 of the first port low
    u_evrt_src_model.set_idx(2'h0);
    wr_reg(5'h02, 8'h52);
    wr_reg(5'h0a, 8'h18);
    tick(4);
    u_evrt_src_model.set_idx(2'h2);
    cnt = 0;
    repeat (6) begin
      tick(1);
      if (index_evt[1] === 1'b1) cnt++;
    end
    chk("index pulses ch2", 8'(cnt), 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
